/* File: logic/etpc_map.svh */
// Register indices, field positions, codes and reset values of the timer.
// Assumes a 32-bit APB with one register per aligned word (byte address = 4 * index).
`ifndef ETPC_MAP_SVH
`define ETPC_MAP_SVH

// Register indices (byte address is four times the index)
`define ETPC_IDX_IRQ 6'h0B
`define ETPC_IDX_UPPER 6'h0F
`define ETPC_IDX_LOWER 6'h10
`define ETPC_IDX_CTRL 6'h11
`define ETPC_IDX_MASK 6'h12

// Control register field positions
`define ETPC_BIT_MODE_HI 7
`define ETPC_BIT_MODE_LO 6
`define ETPC_BIT_RUN 4
`define ETPC_BIT_EDGE 3

// Interrupt status and mask layout
`define ETPC_BIT_OVF 6
`define ETPC_IRQ_BITS 8'h40

// Mode codes
`define ETPC_MODE_EVENT 2'h1
`define ETPC_MODE_TIMER 2'h2
`define ETPC_MODE_PULSE 2'h3

// Reset values and counter maximum
`define ETPC_CTRL_RST 8'h08
`define ETPC_CNT_RST 16'h0000
`define ETPC_CNT_MAX 16'hFFFF
`define ETPC_BYTE_RST 8'h00
`define ETPC_WORD_RST 32'h0000_0000

// Prescaler ratio of the internal count clock
`define ETPC_PRE_DIV 4

`endif

/* File: logic/etpc_pkg.sv */
// Types shared by the event timer and pulse counter.
// Assumes etpc_map.svh holds the numeric constants.
package etpc_pkg;

    // Pulse width measurement progress
    typedef enum logic [0:0] {
        PW_WAIT,
        PW_COUNT
    } etpc_pw_state_e;

    // Control register contents
    typedef struct packed {
        logic [1:0] mode;
        logic run;
        logic edge_fall;
    } etpc_ctrl_s;

endpackage

/* File: logic/etpc_timer.sv */
// Sixteen-bit event timer and pulse width counter with an APB register port.
// Assumes pclk at 200 MHz, event_input_pin synchronous-safe via internal synchroniser.
`timescale 1ns/1ps
`include "etpc_map.svh"

module etpc_timer #(
    parameter int PRE_DIV = `ETPC_PRE_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_input_pin,
    output logic irq
);

    localparam int PW = (PRE_DIV > 1) ? $clog2(PRE_DIV) : 1;

    // Bus phase decode
    wire setup_ph;
    wire access_ph;
    wire [5:0] reg_idx;
    wire aligned;
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign reg_idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);

    // Register hits
    wire hit_upper;
    wire hit_lower;
    wire hit_ctrl;
    wire hit_irq;
    wire hit_mask;
    wire hit_any;
    assign hit_upper = aligned & (reg_idx == `ETPC_IDX_UPPER);
    assign hit_lower = aligned & (reg_idx == `ETPC_IDX_LOWER);
    assign hit_ctrl = aligned & (reg_idx == `ETPC_IDX_CTRL);
    assign hit_irq = aligned & (reg_idx == `ETPC_IDX_IRQ);
    assign hit_mask = aligned & (reg_idx == `ETPC_IDX_MASK);
    assign hit_any = hit_upper | hit_lower | hit_ctrl | hit_irq | hit_mask;

    // Write strobes, taken in the access phase (no wait states)
    wire wr_en;
    wire wr_upper;
    wire wr_lower;
    wire wr_ctrl;
    wire wr_irq;
    wire wr_mask;
    wire [7:0] wbyte;
    assign wr_en = access_ph & pwrite;
    assign wr_upper = wr_en & hit_upper;
    assign wr_lower = wr_en & hit_lower;
    assign wr_ctrl = wr_en & hit_ctrl;
    assign wr_irq = wr_en & hit_irq;
    assign wr_mask = wr_en & hit_mask;
    assign wbyte = pwdata[7:0];

    // Read side effects happen once, at the setup edge
    wire rd_setup;
    wire rd_upper;
    wire cnt_block;
    assign rd_setup = setup_ph & ~pwrite;
    assign rd_upper = rd_setup & hit_upper;
    // Counting is frozen for the whole counter read transfer
    assign cnt_block = psel & ~pwrite & (hit_upper | hit_lower);

    // Register storage
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] preload_ff;
    logic [7:0] lowbuf_ff;
    etpc_pkg::etpc_ctrl_s ctrl_ff;
    etpc_pkg::etpc_ctrl_s nxt_ctrl;
    logic [7:0] stat_ff;
    logic [7:0] mask_ff;
    logic [31:0] prdata_ff;
    logic [PW-1:0] pre_ff;
    logic [2:0] sync_ff;
    etpc_pkg::etpc_pw_state_e pw_ff;
    etpc_pkg::etpc_pw_state_e nxt_pw;

    // Prescaler tick every PRE_DIV clocks
    wire pre_tick;
    assign pre_tick = (pre_ff == PW'(PRE_DIV - 1));

    // Prescaler counter, cleared by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
        end else if (pre_tick) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + PW'(1);
        end
    end

    // Event pin synchroniser plus one stage for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff <= 3'h0;
        end else begin
            sync_ff <= {sync_ff[1:0], event_input_pin};
        end
    end

    // Edge decode on the synchronised level only
    wire pin_rise;
    wire pin_fall;
    wire act_edge;
    wire ret_edge;
    assign pin_rise = sync_ff[1] & ~sync_ff[2];
    assign pin_fall = ~sync_ff[1] & sync_ff[2];
    assign act_edge = ctrl_ff.edge_fall ? pin_fall : pin_rise;
    assign ret_edge = ctrl_ff.edge_fall ? pin_rise : pin_fall;

    // Mode decode
    wire mode_event;
    wire mode_timer;
    wire mode_pulse;
    assign mode_event = (ctrl_ff.mode == `ETPC_MODE_EVENT);
    assign mode_timer = (ctrl_ff.mode == `ETPC_MODE_TIMER);
    assign mode_pulse = (ctrl_ff.mode == `ETPC_MODE_PULSE);

    // Pulse measurement sequencing
    always_comb begin
        nxt_pw = pw_ff;
        if (!(mode_pulse & ctrl_ff.run)) begin
            nxt_pw = etpc_pkg::PW_WAIT;
        end else begin
            unique case (pw_ff)
                etpc_pkg::PW_WAIT: begin
                    // Start only on an edge, never on a level
                    if (act_edge) begin
                        nxt_pw = etpc_pkg::PW_COUNT;
                    end
                end
                etpc_pkg::PW_COUNT: begin
                    // Pin back to its prior level ends the measurement
                    if (ret_edge) begin
                        nxt_pw = etpc_pkg::PW_WAIT;
                    end
                end
            endcase
        end
    end

    // Measurement finished this cycle
    wire pw_done;
    assign pw_done = mode_pulse & ctrl_ff.run & (pw_ff == etpc_pkg::PW_COUNT) & ret_edge;

    // Measurement state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_ff <= etpc_pkg::PW_WAIT;
        end else begin
            pw_ff <= nxt_pw;
        end
    end

    // Count request per mode
    wire inc_req;
    wire inc;
    wire ovf;
    assign inc_req = (mode_event & ctrl_ff.run & act_edge)
                   | (mode_timer & ctrl_ff.run & pre_tick)
                   | (mode_pulse & ctrl_ff.run & (pw_ff == etpc_pkg::PW_COUNT) & pre_tick);
    assign inc = inc_req & ~cnt_block;
    assign ovf = inc & (cnt_ff == `ETPC_CNT_MAX);

    // Counter next value
    always_comb begin
        nxt_cnt = cnt_ff;
        if (wr_upper & ~ctrl_ff.run) begin
            // Stopped counter takes the preload write directly
            nxt_cnt = {wbyte, lowbuf_ff};
        end else if (ovf) begin
            nxt_cnt = preload_ff;
        end else if (inc) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= `ETPC_CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Preload pair, written as a whole by the high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preload_ff <= `ETPC_CNT_RST;
        end else if (wr_upper) begin
            preload_ff <= {wbyte, lowbuf_ff};
        end
    end

    // Low byte holding buffer, shared by writes and reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowbuf_ff <= `ETPC_BYTE_RST;
        end else if (wr_lower) begin
            lowbuf_ff <= wbyte;
        end else if (rd_upper) begin
            lowbuf_ff <= cnt_ff[7:0];
        end
    end

    // Control next value: software write wins over auto clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl.mode = wbyte[`ETPC_BIT_MODE_HI:`ETPC_BIT_MODE_LO];
            nxt_ctrl.run = wbyte[`ETPC_BIT_RUN];
            nxt_ctrl.edge_fall = wbyte[`ETPC_BIT_EDGE];
        end else if (pw_done) begin
            // Of the count events, only a finished pulse measurement drops the run bit
            nxt_ctrl.run = 1'b0;
        end
    end

    // Control register, reset to counter off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff.mode <= 2'(`ETPC_CTRL_RST >> `ETPC_BIT_MODE_LO);
            ctrl_ff.run <= 1'(`ETPC_CTRL_RST >> `ETPC_BIT_RUN);
            ctrl_ff.edge_fall <= 1'(`ETPC_CTRL_RST >> `ETPC_BIT_EDGE);
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Sticky status: write one clears, new overflow wins
    wire [7:0] stat_clr;
    wire [7:0] stat_set;
    assign stat_clr = wr_irq ? wbyte : `ETPC_BYTE_RST;
    assign stat_set = 8'(ovf) << `ETPC_BIT_OVF;

    // Interrupt status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= `ETPC_BYTE_RST;
        end else begin
            stat_ff <= ((stat_ff & ~stat_clr) | stat_set) & `ETPC_IRQ_BITS;
        end
    end

    // Interrupt mask register, disabled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= `ETPC_BYTE_RST;
        end else if (wr_mask) begin
            mask_ff <= wbyte & `ETPC_IRQ_BITS;
        end
    end

    // Read data selection
    wire [7:0] ctrl_rd;
    wire [7:0] rd_byte;
    assign ctrl_rd = {ctrl_ff.mode, 1'b0, ctrl_ff.run, ctrl_ff.edge_fall, 3'h0};
    assign rd_byte = hit_upper ? cnt_ff[15:8] :
                     hit_lower ? lowbuf_ff :
                     hit_ctrl ? ctrl_rd :
                     hit_irq ? stat_ff :
                     hit_mask ? mask_ff : `ETPC_BYTE_RST;

    // Read data captured at the setup edge, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `ETPC_WORD_RST;
        end else if (rd_setup) begin
            prdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // Bus answers
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~hit_any;

    // Level interrupt while any unmasked status bit is set
    assign irq = |(stat_ff & mask_ff);

endmodule

/* File: testbench/etpc_pin_src.sv */
// Far-side model: drives the event pin.
// Assumes the caller enters its tasks just after a pclk edge.
`timescale 1ns/1ps
module etpc_pin_src (
    input wire logic pclk,
    output logic pin
);
    initial pin = 1'b0;
    // Hold a level for c clocks
    task automatic hold(input logic lv, input int c);
        pin <= lv;
        repeat (c) @(posedge pclk);
    endtask
    // High then low, each two clocks or more
    task automatic pulse(input int hi, input int lo);
        hold(1'b1, hi);
        hold(1'b0, lo);
    endtask
endmodule

/* File: testbench/etpc_timer_props.sv */
// Port checks of the timer, bound to etpc_timer.
// Assumes byte addresses are four times the register index.
`timescale 1ns/1ps
module etpc_timer_props #(
    parameter int PRE_DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic event_input_pin,
    input wire logic irq
);
    // Read access phase
    wire rd_acc = psel && penable && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rst; $rose(presetn) |-> !irq; endproperty
    a_rst: assert property (p_rst) else $error("irq after reset");
    property p_ctl; rd_acc && paddr == 8'h44 |-> prdata[2:0] == 3'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl low bits");
    property p_hold; psel && penable |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_fell; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
    a_fell: assert property (p_fell) else $error("irq fell alone");
    // Status data is captured at the setup edge, so compare with irq of that edge
    property p_stat; rd_acc && paddr == 8'h2C && $past(irq) |-> prdata[6]; endproperty
    a_stat: assert property (p_stat) else $error("flag not read");
    property p_mask; rd_acc && paddr == 8'h48 && irq |-> prdata[6]; endproperty
    a_mask: assert property (p_mask) else $error("enable not read");
    property p_sb; rd_acc && paddr == 8'h2C |-> prdata[31:7] == 25'h0 && !prdata[5]; endproperty
    a_sb: assert property (p_sb) else $error("status bits");
    property p_byte; rd_acc && paddr == 8'h3C |-> prdata[31:8] == 24'h0 && !pslverr; endproperty
    a_byte: assert property (p_byte) else $error("byte read");
endmodule
bind etpc_timer etpc_timer_props #(.PRE_DIV(PRE_DIV)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input_pin(event_input_pin),
    .irq(irq));

/* File: testbench/event_timer_pulse_counter_test.sv */
// Self-checking bench of the timer over APB.
// Assumes etpc_timer, etpc_pin_src and the bound checker.
`timescale 1ns/1ps
module event_timer_pulse_counter_test;
    localparam logic [7:0] A_ST = 8'h2C;
    localparam logic [7:0] A_UP = 8'h3C;
    localparam logic [7:0] A_LO = 8'h40;
    localparam logic [7:0] A_CT = 8'h44;
    localparam logic [7:0] A_MK = 8'h48;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rv;
    logic pready, pslverr, pin, irq, lerr;
    logic [15:0] v, w;
    int failures = 0;
    int checked = 0;
    int n, h;
    always #2.5 pclk = ~pclk;
    etpc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_pin(pin), .irq(irq));
    etpc_pin_src src (.pclk(pclk), .pin(pin));
    task automatic end_sim();
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Expected event count: rising sense sees the final rise too
    function automatic int ev_exp(input int k, input int c);
        return (k == 2) ? 0 : c + ((k == 0) ? 1 : 0);
    endfunction
    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rv = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            end_sim();
        end
        @(posedge pclk);
    endtask
    // Counter read: upper first latches the low byte
    task automatic rc();
        xfer(1'b0, A_UP, 8'h00);
        v[15:8] = rv[7:0];
        xfer(1'b0, A_LO, 8'h00);
        v[7:0] = rv[7:0];
    endtask
    // Preload write: low byte then high byte
    task automatic pl(input logic [15:0] p);
        xfer(1'b1, A_LO, p[7:0]);
        xfer(1'b1, A_UP, p[15:8]);
    endtask
    initial begin
        void'($urandom(29786));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, A_CT, 8'h00);
        chk(rv, 8'h08);
        xfer(1'b0, A_MK, 8'h00);
        chk({rv[30:0], irq}, 8'h00);
        xfer(1'b0, 8'h00, 8'h00);
        chk({rv[30:0], lerr}, 8'h01);
        w = 16'($urandom);
        xfer(1'b1, A_LO, w[7:0]);
        rc();
        chk(v, 16'h0000);
        pl(w);
        rc();
        chk(v, w);
        // Timer overflow, flag, mask and clear
        pl(16'hFFF0);
        xfer(1'b1, A_CT, 8'h90);
        n = 0;
        do begin
            xfer(1'b0, A_ST, 8'h00);
            n++;
        end while (rv[6] !== 1'b1 && n < 60);
        chk(rv, 8'h40);
        if (rv[6] !== 1'b1) end_sim();
        chk(irq, 1'b0);
        xfer(1'b1, A_MK, 8'h40);
        chk(irq, 1'b1);
        xfer(1'b0, A_MK, 8'h00);
        chk(rv, 8'h40);
        xfer(1'b0, A_ST, 8'h00);
        chk(rv, 8'h40);
        xfer(1'b0, A_CT, 8'h00);
        chk(rv, 8'h90);
        xfer(1'b1, A_ST, 8'h40);
        chk(irq, 1'b0);
        rc();
        chk(v[15:8], 8'hFF);
        xfer(1'b1, A_CT, 8'h80);
        // Stopped timer holds, running preload write spares the counter
        pl(16'hFF00);
        repeat (16) @(posedge pclk);
        rc();
        chk(v, 16'hFF00);
        xfer(1'b1, A_CT, 8'h90);
        pl(16'h1234);
        rc();
        chk(v[15:8], 8'hFF);
        // Low byte read returns the latched byte, not the live one
        repeat (8) @(posedge pclk);
        xfer(1'b0, A_LO, 8'h00);
        chk(rv, {24'h00_0000, v[7:0]});
        // Reset in mid-run turns the counter off again
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, A_CT, 8'h00);
        chk(rv, 8'h08);
        xfer(1'b0, A_MK, 8'h00);
        chk(rv, 8'h00);
        rc();
        chk(v, 16'h0000);
        // Event count, rising, falling, unused mode
        for (int k = 0; k < 3; k++) begin
            pl(16'h0000);
            n = $urandom_range(3, 6);
            xfer(1'b1, A_CT, (k == 2) ? 8'h10 : (k == 0) ? 8'h50 : 8'h58);
            repeat (n) src.pulse(3, 3);
            src.hold(1'b1, 4);
            xfer(1'b1, A_CT, 8'h00);
            src.hold(1'b0, 4);
            rc();
            chk(v, 16'(ev_exp(k, n)));
        end
        // Pulse width, then hold after the measurement
        pl(16'h0000);
        xfer(1'b1, A_CT, 8'hD0);
        h = $urandom_range(12, 40);
        src.pulse(h, 6);
        xfer(1'b0, A_CT, 8'h00);
        chk(rv, 8'hC0);
        rc();
        w = v;
        chk(w >= h / 4 - 1 && w <= h / 4 + 1, 1'b1);
        src.pulse(h + 8, 6);
        rc();
        chk(v, w);
        // Pulse mode overflow reloads from preload and raises the flag
        pl(16'hFFFC);
        xfer(1'b1, A_CT, 8'hD0);
        src.pulse(24, 6);
        xfer(1'b0, A_ST, 8'h00);
        chk(rv, 8'h40);
        rc();
        chk(v >= 16'hFFFD && v <= 16'hFFFF, 1'b1);
        end_sim();
    end
endmodule
